// [strap_pkg.sv]
`default_nettype none
package strap_pkg;
  // ======================================================
  // strap field positions on port 2 transmit data
  localparam int BW_HI_BIT = 3;
  localparam int BW_LO_BIT = 2;
  localparam int CLASS_HI_BIT = 1;
  localparam int CLASS_LO_BIT = 0;
  // ======================================================
  // values after reset
  localparam logic [1:0] BW_RESET = 2'h0;
  localparam logic [1:0] CLASS_RESET = 2'h0;
  localparam logic [7:0] TXD_RESET = 8'h00;
  localparam logic [7:0] OE_N_RESET = 8'hff; // every pin released
  localparam logic [7:0] OE_N_DRIVE = 8'h00; // every pin driven
  localparam int TX_WIDTH = 8;
  localparam int MII_WIDTH = 4;
  // ======================================================
  // port 2 priority classes
  typedef enum logic [1:0] {
    CLASS_LOW = 2'h0,
    CLASS_NORMAL = 2'h1,
    CLASS_HIGH = 2'h2,
    CLASS_VERY_HIGH = 2'h3
  } prio_class_t;
  // ======================================================
  // bandwidth share per queue, percent, queues 3..0
  localparam logic [31:0] BW_TABLE [4] = '{
    32'h28_1e_14_0a, 32'h37_19_0f_05, 32'h46_14_0a_00,
    32'h19_19_19_19};
endpackage : strap_pkg
`default_nettype wire

// [strap_latch_status_leds.sv]
`default_nettype none
// Behaviour
// [R1] The reset input is active low and holds the whole block in reset.
// [R2] A 25 MHz clock from the board times all logic, including capture.
// [R3] Bandwidth straps come from tx data bits 3 and 2 and are then held.
// [R4] The two-bit bandwidth code selects one of four queue share schemes.
// [R5] Port 2 class straps come from tx data bits 1 (msb) and 0.
// [R6] Class 00 is low, 01 normal, 10 high and 11 very high priority.
// [R7] The broadcast indicator lights while broadcasts are filtered.
// [R8] A failed self-test keeps the broadcast indicator lit steadily.
// [R9] The overflow indicator lights on unicast overflow with drops.
// [R10] After reset tx data is eight bits in gigabit mode, four in MII.
// [R11] The board gives a 125 MHz reference for gigabit transmit clocks.
// [R12] Straps are caught as reset releases, then pins return to tx data.
module strap_latch_status_leds
  import strap_pkg::*;
#(
  parameter int TXW = TX_WIDTH
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_txd_pin,
  input wire logic [7:0] i_tx_data,
  input wire logic i_gigabit_mode,
  input wire logic i_bcast_filtering,
  input wire logic i_post_failed,
  input wire logic i_ucast_overflow_drop,
  output logic [7:0] o_txd_pin,
  output logic [7:0] o_txd_oe_n,
  output logic [1:0] o_queue_bandwidth_scheme_strap,
  output logic [31:0] o_queue_shares,
  output logic [1:0] o_port2_class,
  output logic o_broadcast_filter_indicator,
  output logic o_unicast_overflow_indicator
);
  // ======================================================
  // elaboration check
  // strap positions and the mii nibble split assume a byte bus
  if (TXW != TX_WIDTH) begin : bad_width_g
    $error("only an 8 bit transmit bus is served");
  end

  // ======================================================
  // strap capture
  // pins float as inputs during reset; the first clocked cycle after
  // release catches them, so no port value enters an async reset
  // limitation: a strap that moves around that first edge is taken at
  // whatever level it shows then; nothing filters it
  logic armed_r, armed_nxt;
  logic [1:0] bw_r, bw_nxt;
  logic [1:0] cls_r, cls_nxt;
  logic [31:0] shares_r, shares_nxt;

  // one table lookup, shared by the next-state logic
  function automatic logic [31:0] share_of(input logic [1:0] code);
    share_of = BW_TABLE[code];
  endfunction : share_of

  // capture once, on the first edge after reset rises
  always_comb begin
    armed_nxt = 1'b1;
    bw_nxt = bw_r;
    cls_nxt = cls_r;
    if (!armed_r) begin
      bw_nxt = {i_txd_pin[BW_HI_BIT], i_txd_pin[BW_LO_BIT]}; // [R3] [R12]
      cls_nxt = {i_txd_pin[CLASS_HI_BIT], i_txd_pin[CLASS_LO_BIT]}; // [R5]
    end
    shares_nxt = share_of(bw_nxt); // [R4]
  end

  // async active-low reset, constants only
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin // [R1]
      armed_r <= 1'b0;
      bw_r <= BW_RESET;
      cls_r <= CLASS_RESET;
      shares_r <= BW_TABLE[BW_RESET];
    end else begin
      armed_r <= armed_nxt;
      bw_r <= bw_nxt;
      cls_r <= cls_nxt;
      shares_r <= shares_nxt;
    end
  end

  // ======================================================
  // transmit data pins and indicators
  logic [7:0] txd_r, txd_nxt;
  logic [7:0] oe_n_r, oe_n_nxt;
  logic bc_r, bc_nxt;
  logic ov_r, ov_nxt;

  // mii mode keeps the upper nibble low so the unused pins stay quiet; drivers
  // wait one cycle past capture so they never fight the strap resistors
  always_comb begin
    txd_nxt = TXD_RESET;
    oe_n_nxt = OE_N_RESET;
    if (armed_r) begin
      oe_n_nxt = OE_N_DRIVE; // [R12]
      txd_nxt = i_gigabit_mode ? i_tx_data
                               : {4'h0, i_tx_data[MII_WIDTH-1:0]}; // [R10]
    end
    bc_nxt = i_post_failed || i_bcast_filtering; // [R7] [R8]
    ov_nxt = i_ucast_overflow_drop; // [R9]
  end

  // async active-low reset leaves every pin released and both lamps dark
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin // [R1]
      txd_r <= TXD_RESET;
      oe_n_r <= OE_N_RESET;
      bc_r <= 1'b0;
      ov_r <= 1'b0;
    end else begin
      txd_r <= txd_nxt;
      oe_n_r <= oe_n_nxt;
      bc_r <= bc_nxt;
      ov_r <= ov_nxt;
    end
  end

  // every output is a bare flip-flop, no logic after the register
  assign o_txd_pin = txd_r;
  assign o_txd_oe_n = oe_n_r;
  assign o_queue_bandwidth_scheme_strap = bw_r;
  assign o_queue_shares = shares_r;
  assign o_port2_class = cls_r; // [R6] encoding as prio_class_t
  assign o_broadcast_filter_indicator = bc_r;
  assign o_unicast_overflow_indicator = ov_r;

  // ======================================================
  // checks
  // all are clocked on the system clock and sleep while reset is low,
  // so the async clear in mid-run never trips them; anything that looks
  // back across a reset guards itself with the past reset level

  // straps and scheme frozen once the capture edge is over
  strap_hold_a: assert property ( // [R3]
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    armed_r |=> $stable(bw_r) && $stable(cls_r))
    else $error("straps changed after capture");
  share_hold_a: assert property ( // [R4]
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    armed_r |=> $stable(o_queue_shares))
    else $error("share scheme moved after capture");

  // the capture edge takes the pin levels seen at that very edge
  strap_take_a: assert property ( // [R5]
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    !armed_r |=> bw_r == $past(i_txd_pin[3:2])
      && cls_r == {$past(i_txd_pin[1]), $past(i_txd_pin[0])})
    else $error("strap not taken from tx data");
  strap_out_a: assert property ( // [R3]
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    !armed_r |=> o_queue_bandwidth_scheme_strap == $past(i_txd_pin[3:2]))
    else $error("bandwidth strap output wrong");

  // one capture per reset, taking exactly one edge
  arm_once_a: assert property ( // [R12]
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    !armed_r |=> armed_r)
    else $error("capture took more than one edge");
  arm_stay_a: assert property ( // [R12]
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    armed_r |=> armed_r)
    else $error("capture rearmed without reset");

  // share table follows the captured code
  share_sel_a: assert property ( // [R4]
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    o_queue_shares == BW_TABLE[o_queue_bandwidth_scheme_strap])
    else $error("share scheme mismatch");

  // pins held off until the capture edge has passed, then driven for
  // good; a driver before that would override the strap resistors
  pins_float_a: assert property ( // [R12]
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    !armed_r |-> o_txd_oe_n == OE_N_RESET
      && o_txd_pin == TXD_RESET)
    else $error("pins driven before capture");
  pins_drive_a: assert property ( // [R12]
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    $rose(armed_r) |=> o_txd_oe_n == OE_N_DRIVE)
    else $error("pins not released to output");
  drive_stay_a: assert property ( // [R12]
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    $past(armed_r) && armed_r |-> o_txd_oe_n == OE_N_DRIVE)
    else $error("pins stopped driving after capture");

  // transmit data, full byte or low nibble
  gig_byte_a: assert property ( // [R10]
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    armed_r && i_gigabit_mode |=> o_txd_pin == $past(i_tx_data))
    else $error("gigabit data wrong");
  mii_nibble_a: assert property ( // [R10]
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    armed_r && !i_gigabit_mode |=> o_txd_pin[7:4] == 4'h0
      && o_txd_pin[3:0] == $past(i_tx_data[3:0]))
    else $error("mii data wrong");

  // broadcast indicator: filtering or a failed self-test; the lamp is
  // dark in reset, so the edge just after release is not compared
  post_led_a: assert property ( // [R8]
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    i_post_failed |=> o_broadcast_filter_indicator)
    else $error("self-test failure not shown");
  bcast_led_a: assert property ( // [R7]
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    $past(i_rst_n) |-> o_broadcast_filter_indicator
      == $past(i_bcast_filtering || i_post_failed))
    else $error("broadcast indicator wrong");
  bcast_off_a: assert property ( // [R7]
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    !i_bcast_filtering && !i_post_failed |=> !o_broadcast_filter_indicator)
    else $error("broadcast indicator lit with no cause");

  // overflow indicator follows the drop flag one cycle later
  ovfl_led_a: assert property ( // [R9]
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    i_ucast_overflow_drop |=> o_unicast_overflow_indicator)
    else $error("overflow indicator missed");
  ovfl_off_a: assert property ( // [R9]
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    !i_ucast_overflow_drop |=> !o_unicast_overflow_indicator)
    else $error("overflow indicator stuck");
endmodule : strap_latch_status_leds
`default_nettype wire

// [strap_phy.sv]
`default_nettype none
// ==================================
// port 2 phy side: strap resistors on tx pins
module strap_phy (
  input wire logic [7:0] i_strap,
  input wire logic [7:0] i_txd,
  input wire logic [7:0] i_oe_n,
  output logic [7:0] o_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // undriven pins fall to the resistor level
  assign o_pin = (i_strap & i_oe_n) | (i_txd & ~i_oe_n);
endmodule : strap_phy
`default_nettype wire

// [tb_strap_latch_status_leds.sv]
`default_nettype none
module tb_strap_latch_status_leds
  import strap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, gig = 1, filt = 0, post = 0, drop = 0;
  logic [7:0] strap = 8'h00, data = 8'h00, pin, txd, oe_n;
  logic [1:0] bw, cls;
  logic [31:0] shr;
  logic bled, oled;
  int error_cnt = 0, comparisons = 0, cycles = 0;
  logic gtx_ref = 0;
  int gtx_edges = 0;
  strap_phy strap_phy_inst (.i_strap(strap), .i_txd(txd), .i_oe_n(oe_n),
    .o_pin(pin));
  strap_latch_status_leds strap_latch_status_leds_inst (.i_ref_clk(clk),
    .i_rst_n(rst_n), .i_txd_pin(pin), .i_tx_data(data),
    .i_gigabit_mode(gig), .i_bcast_filtering(filt), .i_post_failed(post),
    .i_ucast_overflow_drop(drop), .o_txd_pin(txd), .o_txd_oe_n(oe_n),
    .o_queue_bandwidth_scheme_strap(bw), .o_queue_shares(shr),
    .o_port2_class(cls), .o_broadcast_filter_indicator(bled),
    .o_unicast_overflow_indicator(oled));
  // ==================================
  // clock and hang guard
  initial forever #20 clk = ~clk;
  // board gigabit reference, five edges to every system clock edge
  initial forever #4 gtx_ref = ~gtx_ref;
  always @(posedge gtx_ref) gtx_edges++;
  always @(posedge clk) begin
    cycles++;
    if (cycles > 1000) begin
      error_cnt++;
      stop_test();
    end
  end
  // ==================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %0t got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  // reset with straps held, released off the edge
  task automatic boot(input logic [3:0] s);
    rst_n = 0;
    strap = {4'h0, s};
    step(16);
    check(oe_n, 8'hff);
    check(bw, 2'h0);
    rst_n = 1;
    step(3);
  endtask : boot
  // every bandwidth code and every class code
  task automatic strap_codes;
    prio_class_t want [4] = '{CLASS_VERY_HIGH, CLASS_HIGH, CLASS_NORMAL,
      CLASS_LOW};
    for (int k = 0; k < 4; k++) begin
      boot({k[1:0], ~k[1:0]});
      check(bw, k[1:0]);
      check(shr, BW_TABLE[k]);
      check(cls, 2'(~k[1:0]));
      check(cls, want[k]);
      check(oe_n, 8'h00);
    end
  endtask : strap_codes
  // straps gone from pins, data passes; the reference runs alongside
  task automatic tx_data;
    int base;
    base = gtx_edges;
    data = 8'ha5;
    step(2);
    check(gtx_edges - base, 10);
    check(txd, 8'ha5);
    check(bw, 2'h3);
    gig = 0;
    step(2);
    check(txd, 8'h05);
  endtask : tx_data
  task automatic leds;
    filt = 1;
    step(2);
    check(bled, 1'b1);
    filt = 0;
    post = 1;
    drop = 1;
    step(2);
    check(bled, 1'b1);
    check(oled, 1'b1);
    step(2);
    check(bled, 1'b1);
    post = 0;
    drop = 0;
    step(2);
    check({bled, oled}, 2'h0);
  endtask : leds
  task automatic stop_test;
    if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  initial begin
    strap_codes();
    tx_data();
    leds();
    stop_test();
  end
endmodule : tb_strap_latch_status_leds
`default_nettype wire
